//--- ddrmr_pkg.sv
/*
  ddrmr_pkg: constants and carrier types for the mode-word load logic.
  assumes: included before ddrmr_load.sv; no other dependencies.
*/
`default_nettype none
package ddrmr_pkg;
  localparam int ADDR_W = 14;
  // positions of fields inside operating_mode_word
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int TM_BIT = 7;
  localparam int DLL_BIT = 8;
  localparam int WR_LSB = 9;
  localparam int PD_BIT = 12;
  localparam int TOP_BIT = 13;
  // bank-select codes that route a load command
  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_EXT_ONE = 2'h1;
  // field codes
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_CODE_MIN = 3'h3;
  localparam logic [2:0] CL_CODE_MAX = 3'h6;
  localparam logic [2:0] WR_CODE_MIN = 3'h1;
  localparam logic [2:0] WR_CODE_MAX = 3'h5;
  // wait after a dll reset before reads, in clock cycles
  localparam logic [7:0] DLL_LOCK_CYCLES = 8'hc8;
  // reset values
  localparam logic [ADDR_W-1:0] WORD_RST = 14'h0000;
  localparam logic [2:0] CODE_RST = 3'h0;
  localparam logic [4:0] DAL_RST = 5'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
  } ddrmr_pins_t;

  typedef struct packed {
    logic burst_len_eight;
    logic burst_len_ok;
    logic burst_interleave;
    logic [2:0] cas_cycles;
    logic cas_ok;
    logic [2:0] wr_cycles;
    logic wr_ok;
    logic powerdown_exit_speed;
    logic [4:0] autoprecharge_write_interval;
    logic config_error;
  } ddrmr_cfg_t;
endpackage
`default_nettype wire

//--- ddrmr_load.sv
/*
  ddrmr_load: decodes mode-word load commands seen on the command and address
  pins and holds the operating configuration that the rest of the device uses.
  assumes: command pins come from another clock domain and are synchronised
  here; banks_precharged comes from bank logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ddrmr_load
  import ddrmr_pkg::*;
#(
  parameter bit NARROW_ROWS = 1'b0,
  parameter logic [4:0] PRECHARGE_CYCLES = 5'h05
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic core_clk_en,
  input wire ddrmr_pins_t pins,
  input wire logic banks_precharged,
  output logic [ADDR_W-1:0] operating_mode_word,
  output logic [ADDR_W-1:0] ext_mode_word_one,
  output logic mode_loaded,
  output logic ext_loaded,
  output logic mode_word_load_cmd,
  output logic ext_mode_word_load_cmd,
  output logic dll_reset_req,
  output logic dll_settling,
  output logic load_while_active,
  output ddrmr_cfg_t cfg
);

  typedef struct packed {
    ddrmr_pins_t s1;
    ddrmr_pins_t s2;
    ddrmr_pins_t s3;
    ddrmr_pins_t filt;
    logic prev_load;
    logic [ADDR_W-1:0] word;
    logic [ADDR_W-1:0] ext_word;
    logic loaded;
    logic ext_ok;
    logic mode_strobe;
    logic ext_strobe;
    logic dll_req;
    logic [7:0] dll_count;
    logic busy_load;
    ddrmr_cfg_t cfg;
  } ddrmr_state_t;

  localparam ddrmr_pins_t PINS_RST = '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1,
    cas_n: 1'b1, we_n: 1'b1, ba: 2'h0, addr: WORD_RST};
  localparam ddrmr_cfg_t CFG_RST = '{burst_len_eight: 1'b0, burst_len_ok: 1'b0,
    burst_interleave: 1'b0, cas_cycles: CODE_RST, cas_ok: 1'b0,
    wr_cycles: CODE_RST, wr_ok: 1'b0, powerdown_exit_speed: 1'b0,
    autoprecharge_write_interval: DAL_RST, config_error: 1'b1};

  ddrmr_state_t st;
  ddrmr_state_t next_st;
  logic is_load;
  logic accept_mode;
  logic accept_ext;
  logic [ADDR_W-1:0] sampled_addr;

  always_comb begin
    logic [2:0] bl_code;
    logic [2:0] cl_code;
    logic [2:0] wr_code;
    logic [2:0] wr_cyc;
    bl_code = CODE_RST;
    cl_code = CODE_RST;
    wr_code = CODE_RST;
    wr_cyc = CODE_RST;
    next_st = st;
    // three-stage pin synchroniser; a change counts once stages 2 and 3 agree
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.filt = st.s3;
    end
    // load command: cs, ras, cas, we all low while cke is high
    is_load = st.filt.cke && !st.filt.cs_n && !st.filt.ras_n &&
      !st.filt.cas_n && !st.filt.we_n;
    next_st.prev_load = is_load;
    // one load per held command; the controller returns to nop between loads
    accept_mode = is_load && !st.prev_load && (st.filt.ba == BA_MODE);
    accept_ext = is_load && !st.prev_load && (st.filt.ba == BA_EXT_ONE);
    // the x16 part has no top address pin, so that bit never reaches the word
    sampled_addr = st.filt.addr;
    if (NARROW_ROWS) begin
      sampled_addr[TOP_BIT] = 1'b0;
    end
    next_st.mode_strobe = accept_mode;
    next_st.ext_strobe = accept_ext;
    next_st.dll_req = 1'b0;
    // accepted anyway, but flagged: the bank logic cannot be kept consistent
    next_st.busy_load = (accept_mode || accept_ext) && !banks_precharged;
    if (accept_mode) begin
      next_st.word = sampled_addr;
      next_st.loaded = 1'b1;
      next_st.dll_req = sampled_addr[DLL_BIT];
    end
    if (accept_ext) begin
      next_st.ext_word = sampled_addr;
      next_st.ext_ok = 1'b1;
    end
    // dll lock wait counter restarts on every reset request
    if (next_st.dll_req) begin
      next_st.dll_count = DLL_LOCK_CYCLES;
    end else if (st.dll_count != COUNT_RST) begin
      next_st.dll_count = st.dll_count - 8'h01;
    end
    // decode always follows the stored word, so fields change only on a load or at the first enabled clock after reset
    bl_code = next_st.word[BL_LSB +: 3];
    cl_code = next_st.word[CL_LSB +: 3];
    wr_code = next_st.word[WR_LSB +: 3];
    next_st.cfg.burst_len_eight = (bl_code == BL_CODE_8);
    next_st.cfg.burst_len_ok = (bl_code == BL_CODE_4) || (bl_code == BL_CODE_8);
    next_st.cfg.burst_interleave = next_st.word[BT_BIT];
    // code equals latency in whole cycles; there is no half-cycle encoding
    next_st.cfg.cas_ok = (cl_code >= CL_CODE_MIN) && (cl_code <= CL_CODE_MAX);
    next_st.cfg.cas_cycles = next_st.cfg.cas_ok ? cl_code : CODE_RST;
    next_st.cfg.wr_ok = (wr_code >= WR_CODE_MIN) && (wr_code <= WR_CODE_MAX);
    wr_cyc = wr_code + 3'h1;
    next_st.cfg.wr_cycles = next_st.cfg.wr_ok ? wr_cyc : CODE_RST;
    next_st.cfg.autoprecharge_write_interval =
      {2'h0, next_st.cfg.wr_cycles} + PRECHARGE_CYCLES;
    next_st.cfg.powerdown_exit_speed = next_st.word[PD_BIT];
    // reserved codes, the test bit and a set top bit on x8 all mark the word bad
    next_st.cfg.config_error = !next_st.loaded || !next_st.cfg.burst_len_ok ||
      !next_st.cfg.cas_ok || !next_st.cfg.wr_ok || next_st.word[TM_BIT] ||
      next_st.word[TOP_BIT];
  end

  // no path from here reaches the array, so loads leave stored data intact
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st.s1 <= PINS_RST;
      st.s2 <= PINS_RST;
      st.s3 <= PINS_RST;
      st.filt <= PINS_RST;
      st.prev_load <= 1'b0;
      st.word <= WORD_RST;
      st.ext_word <= WORD_RST;
      st.loaded <= 1'b0;
      st.ext_ok <= 1'b0;
      st.mode_strobe <= 1'b0;
      st.ext_strobe <= 1'b0;
      st.dll_req <= 1'b0;
      st.dll_count <= COUNT_RST;
      st.busy_load <= 1'b0;
      st.cfg <= CFG_RST;
    end else if (core_clk_en) begin
      st <= next_st;
    end
  end

  assign operating_mode_word = st.word;
  assign ext_mode_word_one = st.ext_word;
  assign mode_loaded = st.loaded;
  assign ext_loaded = st.ext_ok;
  assign mode_word_load_cmd = st.mode_strobe;
  assign ext_mode_word_load_cmd = st.ext_strobe;
  assign dll_reset_req = st.dll_req;
  assign dll_settling = (st.dll_count != COUNT_RST) ? 1'b1 : 1'b0;
  assign load_while_active = st.busy_load;
  assign cfg = st.cfg;

  a_main_load_word: assert property (@(posedge core_clk) disable iff (reset)
    (core_clk_en && accept_mode) |=> (st.word == $past(sampled_addr)))
    else $error("main load did not capture address");
  a_ext_not_main: assert property (@(posedge core_clk) disable iff (reset)
    (core_clk_en && accept_ext) |=> (st.word == $past(st.word)) &&
    (st.ext_word == $past(sampled_addr)))
    else $error("extended load disturbed main word");
  a_word_only_load: assert property (@(posedge core_clk) disable iff (reset)
    (st.word != $past(st.word)) |-> $past(accept_mode && core_clk_en))
    else $error("main word changed without a main load");
  a_burst_len_map: assert property (@(posedge core_clk) disable iff (reset)
    st.cfg.burst_len_ok |-> (st.cfg.burst_len_eight ==
    (st.word[BL_LSB +: 3] == BL_CODE_8)))
    else $error("burst length decode wrong");
  a_burst_reserved: assert property (@(posedge core_clk) disable iff (reset)
    (st.loaded && (st.word[BL_LSB +: 3] == 3'h0)) |-> st.cfg.config_error)
    else $error("reserved burst code not flagged");
  a_cas_range: assert property (@(posedge core_clk) disable iff (reset)
    st.cfg.cas_ok |-> (st.cfg.cas_cycles >= 3'h3) && (st.cfg.cas_cycles <= 3'h6) &&
    (st.cfg.cas_cycles == st.word[CL_LSB +: 3]))
    else $error("read latency decode wrong");
  a_wr_interval: assert property (@(posedge core_clk) disable iff (reset)
    st.cfg.wr_ok |-> (st.cfg.autoprecharge_write_interval ==
    {2'h0, st.word[WR_LSB +: 3]} + 5'h01 + PRECHARGE_CYCLES))
    else $error("write interval not recovery plus precharge");
  a_dll_pulse: assert property (@(posedge core_clk) disable iff (reset)
    (core_clk_en && accept_mode && sampled_addr[DLL_BIT]) |=>
    dll_reset_req ##1 (dll_settling || !core_clk_en))
    else $error("dll reset request missing");
  a_no_dll_pulse: assert property (@(posedge core_clk) disable iff (reset)
    dll_reset_req |-> $past(accept_mode && sampled_addr[DLL_BIT]))
    else $error("spurious dll reset request");
  a_pd_exit_bit: assert property (@(posedge core_clk) disable iff (reset)
    st.cfg.powerdown_exit_speed == st.word[PD_BIT])
    else $error("power-down exit speed mismatch");
  a_order_bit: assert property (@(posedge core_clk) disable iff (reset)
    $rose(st.word[BT_BIT]) |-> st.cfg.burst_interleave)
    else $error("burst order does not follow word");
  a_busy_flag: assert property (@(posedge core_clk) disable iff (reset)
    (core_clk_en && accept_mode && !banks_precharged) |=> load_while_active)
    else $error("load with open banks not flagged");

  c_main_load: cover property (@(posedge core_clk) disable iff (reset)
    mode_word_load_cmd && !cfg.config_error);
  c_ext_load: cover property (@(posedge core_clk) disable iff (reset)
    ext_mode_word_load_cmd);
  c_dll_wait_done: cover property (@(posedge core_clk) disable iff (reset)
    $fell(dll_settling));
  c_burst_eight: cover property (@(posedge core_clk) disable iff (reset)
    mode_word_load_cmd ##1 cfg.burst_len_eight);

endmodule
`default_nettype wire

//--- ddrmr_ctrl_model.sv
/*
  ddrmr_ctrl_model: memory-controller side that issues load commands on the pins.
  assumes: a free-running core_clk; calls come from the bench at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ddrmr_ctrl_model
  import ddrmr_pkg::*;
(
  input wire logic core_clk,
  output var ddrmr_pins_t pins
);
  initial begin
    pins = '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 2'h0,
             addr: 14'h0000};
  end

  task automatic power_up();
    @(negedge core_clk);
    pins.cke = 1'b1;
  endtask

  // full word every time, held four cycles, then a long nop gap
  task automatic load(input logic [1:0] ba, input logic [ADDR_W-1:0] word, input logic cke);
    @(negedge core_clk);
    pins.cke = cke;
    pins.ba = ba;
    pins.addr = word;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'h0;
    repeat (4) @(negedge core_clk);
    pins.cke = 1'b1;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'hf;
    // released lines must not keep the old value
    pins.addr = ~word;
    pins.ba = ~ba;
    repeat (8) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  tb_top: self-checking bench for ddrmr_load with the controller model.
  assumes: ddrmr_pkg, ddrmr_load and ddrmr_ctrl_model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ddrmr_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic banks_precharged = 1'b1;
  ddrmr_pins_t pins;
  logic [ADDR_W-1:0] op_word, ext_word;
  logic mode_loaded, ext_loaded, mode_pulse, ext_pulse, dll_req, dll_settling, act_flag;
  ddrmr_cfg_t cfg;
  int fails = 0;
  int checks = 0;
  int n_mode = 0, n_ext = 0, n_dll = 0, n_act = 0, settle = 0;
  logic [2:0] cas_tab [8] = '{3'h0, 3'h0, 3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
  logic [2:0] wr_tab [8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h0};

  always #10 core_clk = ~core_clk;

  ddrmr_ctrl_model u_ctrl (.core_clk(core_clk), .pins(pins));
  ddrmr_load #(.NARROW_ROWS(1'b0), .PRECHARGE_CYCLES(5'h05)) u_dut (
    .core_clk(core_clk), .reset(reset), .core_clk_en(1'b1), .pins(pins),
    .banks_precharged(banks_precharged), .operating_mode_word(op_word),
    .ext_mode_word_one(ext_word), .mode_loaded(mode_loaded), .ext_loaded(ext_loaded),
    .mode_word_load_cmd(mode_pulse), .ext_mode_word_load_cmd(ext_pulse),
    .dll_reset_req(dll_req), .dll_settling(dll_settling), .load_while_active(act_flag),
    .cfg(cfg));

  // one-cycle pulses are counted at the edge where they stand; settle counts every cycle of dll_settling
  always @(posedge core_clk) begin
    if (mode_pulse === 1'b1) n_mode <= n_mode + 1;
    if (ext_pulse === 1'b1) n_ext <= n_ext + 1;
    if (dll_req === 1'b1) n_dll <= n_dll + 1;
    if (act_flag === 1'b1) n_act <= n_act + 1;
    if (dll_settling === 1'b1) settle <= settle + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic ddrmr_cfg_t exp_cfg(logic [13:0] a, logic [2:0] cas, logic [2:0] wr);
    ddrmr_cfg_t c;
    c.burst_len_eight = (a[2:0] == 3'h3);
    c.burst_len_ok = (a[2:0] == 3'h2) || (a[2:0] == 3'h3);
    c.burst_interleave = a[3];
    c.cas_cycles = cas;
    c.cas_ok = (cas != 3'h0);
    c.wr_cycles = wr;
    c.wr_ok = (wr != 3'h0);
    c.powerdown_exit_speed = a[12];
    c.autoprecharge_write_interval = {2'h0, wr} + 5'h05;
    c.config_error = !c.burst_len_ok || !c.cas_ok || !c.wr_ok || a[7] || a[13];
    return c;
  endfunction

  task automatic final_report();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge core_clk);
    fails++;
    final_report();
  end

  initial begin
    logic [ADDR_W-1:0] a, keep;
    ddrmr_cfg_t cfg_keep;
    int m, s0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    check(cfg, 32'h1);
    check({op_word, mode_loaded, dll_settling}, 32'h0);
    u_ctrl.power_up();
    for (int i = 0; i < 8; i++) begin
      a = {1'b0, i[1], i[2:0], 2'b00, i[2:0], i[0], i[2:0]};
      m = n_mode;
      u_ctrl.load(BA_MODE, a, 1'b1);
      check(n_mode, m + 1);
      check(op_word, a);
      check(cfg, exp_cfg(a, cas_tab[i], wr_tab[i]));
      $display("row %0d done", i);
    end
    check({n_dll, n_act, n_ext}, 32'h0);
    check(mode_loaded, 1'b1);
    keep = op_word;
    cfg_keep = cfg;
    m = n_ext;
    u_ctrl.load(BA_EXT_ONE, 14'h2a55, 1'b1);
    check(ext_word, 14'h2a55);
    check({n_ext, ext_loaded}, {m + 1, 1'b1});
    check({op_word, cfg}, {keep, cfg_keep});
    $display("extended load done");
    m = n_mode + n_ext;
    u_ctrl.load(2'h2, 14'h1fff, 1'b1);
    u_ctrl.load(BA_MODE, 14'h1fff, 1'b0);
    check(n_mode + n_ext, m);
    check(op_word, keep);
    $display("refused loads done");
    m = n_dll;
    s0 = settle;
    a = 14'h0763;
    u_ctrl.load(BA_MODE, a, 1'b1);
    check(n_dll, m + 1);
    check(cfg, exp_cfg(a, 3'h6, 3'h4));
    repeat (220) @(negedge core_clk);
    check(settle - s0, 200);
    $display("dll reset done");
    m = n_act;
    banks_precharged = 1'b0;
    a = 14'h2e9a;
    u_ctrl.load(BA_MODE, a, 1'b1);
    banks_precharged = 1'b1;
    check(n_act, m + 1);
    check(op_word, a);
    check(cfg.config_error, 1'b1);
    $display("open bank and reserved bits done");
    final_report();
  end
endmodule
`default_nettype wire
